// >>> rtl/ttc_defs.svh
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH
// Notes on behaviour
// - timers 0 and 1 have four modes each; modes 0-2 alike, mode 3 differs.
// - mode 0 counts 13 bits: high byte plus low five bits of low byte.
// - rollover from all ones to zero sets that timer's overflow flag.
// - count only while run is 1 and qualify is 0 or irq pin high.
// - setting run does not clear the count; counting resumes from it.
// - qualify bit of timer 1 is mode bit 7, timer 0 is bit 3.
// - mode 1 is mode 0 with the full 16-bit count.
// - mode 2 low byte counts, reloads from high byte on overflow, sets flag.
// - timer 1 in mode 3 holds its count as if run were cleared.
// - timer 0 mode 3: low byte own counter; high byte uses timer 1 run/flag.
// - timer 1 then runs unless in mode 3, and sets no flag.
// - timer 2 is 16 bits; select picks timing or counting; modes by control.
// - capture mode, external enable clear: 16-bit count, overflow sets flag.
// - capture mode, enable set: pin fall copies count to capture, sets flag.
// - timer 2 external and overflow flags share one request output.
// - capture mode never reloads; counting goes on after a capture.
// - down-count enable resets to 0; when set, pin level picks direction.
// - up auto-reload: overflow at ffff sets flag, reloads from reload pair.
// - up auto-reload with enable: pin fall reloads and sets external flag.
// - up/down mode, pin high: count up, overflow sets flag and reloads.
// - pin low: count down; at reload value set flag, load ffff.
// - up/down mode: external flag toggles on each wrap, raises no request.
// - timer 2 select 0 counts machine cycles, 1 counts count-pin falls.
// - timer 2 runs only while its run bit is 1.
`define TTC_ADDR_W 6
`define TTC_OFF_MODE01 6'h00
`define TTC_OFF_CTL01 6'h04
`define TTC_OFF_T0L 6'h08
`define TTC_OFF_T0H 6'h0c
`define TTC_OFF_T1L 6'h10
`define TTC_OFF_T1H 6'h14
`define TTC_OFF_T2CTL 6'h18
`define TTC_OFF_THIRD_TIMER_MODE 6'h1c
`define TTC_OFF_T2CL 6'h20
`define TTC_OFF_T2CH 6'h24
`define TTC_OFF_T2RL 6'h28
`define TTC_OFF_T2RH 6'h2c
`define TTC_MODE_STRIDE 4
`define TTC_MODE_M 0
`define TTC_MODE_CT 2
`define TTC_MODE_Q 3
`define TTC_CTL_TF1 7
`define TTC_CTL_TR1 6
`define TTC_CTL_TF0 5
`define TTC_CTL_TR0 4
`define TTC_T2C_TF 7
`define TTC_T2C_EXF 6
`define TTC_T2C_RXB 5
`define TTC_T2C_TXB 4
`define TTC_T2C_EXEN 3
`define TTC_T2C_RUN 2
`define TTC_T2C_CT 1
`define TTC_T2C_CAP 0
`define TTC_T2M_DOWN_COUNT_ENABLE 0
`define TTC_LOW_W 5
`define TTC_PIN_T0CNT 0
`define TTC_PIN_T2CNT 2
`define TTC_PIN_IRQA 3
`define TTC_PIN_T2_CAPTURE_DIRECTION_PIN 5
`define TTC_NPINS 6
`define TTC_MCYC_DIV 12
`define TTC_PRE_W 4
`define TTC_ONES8 8'hff
`define TTC_ONES16 16'hffff
`define TTC_STATE_RST '0
`endif

// >>> rtl/ttc_pkg.sv
`include "ttc_defs.svh"
package ttc_pkg;
    typedef enum logic [1:0] {
        TTC_M13    = 2'b00,
        TTC_M16    = 2'b01,
        TTC_M8RL   = 2'b10,
        TTC_MSPLIT = 2'b11
    } ttc_tmode_e;
    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [`TTC_ADDR_W-1:0] address;
        logic [3:0]             byteenable;
        logic [31:0]            writedata;
    } ttc_avs_req_s;
    // order fixes the bit index of each pin in the sync vectors
    typedef struct packed {
        logic t2_capture_direction_pin;
        logic ext_irq_pin_b;
        logic ext_irq_pin_a;
        logic t2_count_pin;
        logic t1_count_pin;
        logic t0_count_pin;
    } ttc_pins_s;
    typedef struct packed {
        logic t2_irq_req;
        logic timer1_overflow_flag;
        logic timer0_overflow_flag;
    } ttc_flags_s;
    typedef struct packed {
        logic [7:0]             timer01_mode_register;
        logic [1:0]             run;
        logic [1:0]             ovf_flag;
        logic [1:0][7:0]        low_byte;
        logic [1:0][7:0]        high_byte;
        logic [7:0]             third_timer_control;
        logic [1:0]             third_timer_mode;
        logic [7:0]             t2_count_low;
        logic [7:0]             t2_count_high;
        logic [7:0]             t2_reload_low;
        logic [7:0]             t2_reload_high;
        logic [`TTC_PRE_W-1:0]  prescale;
        logic [`TTC_NPINS-1:0]  sync1;
        logic [`TTC_NPINS-1:0]  sync2;
        logic [`TTC_NPINS-1:0]  prev;
        logic                   ack;
        logic [7:0]             rdata;
    } ttc_state_s;
endpackage : ttc_pkg

// >>> rtl/ttc_top.sv
`timescale 1ns/10ps
`include "ttc_defs.svh"
module ttc_top #(
    parameter int unsigned MCYC_DIV = `TTC_MCYC_DIV
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  ce_i,
    input  wire ttc_pkg::ttc_avs_req_s avs_req_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire ttc_pkg::ttc_pins_s    pins_i,
    output ttc_pkg::ttc_flags_s        flags_o
);
    import ttc_pkg::*;

    localparam logic [`TTC_PRE_W-1:0] PRE_LAST = `TTC_PRE_W'(MCYC_DIV - 1);

    ttc_state_s             st_q;
    ttc_state_s             st_d;
    logic [`TTC_NPINS-1:0]  pin_lvl;
    logic [`TTC_NPINS-1:0]  pin_fall;
    logic                   mcyc;
    logic [1:0]             set_f;
    logic [1:0]             lo_tick;
    logic                   split0;
    ttc_tmode_e             mf;
    logic [12:0]            c13;
    logic [15:0]            c16;
    logic [15:0]            t2c;
    logic [15:0]            t2r;
    logic [15:0]            t2n;
    logic                   t2_tick;
    logic                   t2_baud;
    logic                   t2_cap;
    logic                   t2_updown;
    logic                   t2_set_tf;
    logic                   t2_set_ex;
    logic                   t2_tog_ex;
    logic                   req;
    logic                   wr_act;
    logic [7:0]             wd;
    logic [7:0]             rd8;
    logic [`TTC_ADDR_W-1:0] addr;
    logic [7:0]             md;
    logic [7:0]             t2ctl;

    // a request completes only in an enabled cycle, so ce low can never drop a write
    assign req               = avs_req_i.read | avs_req_i.write;
    assign avs_waitrequest_o = req & ~(st_q.ack & ce_i);
    assign avs_readdata_o    = {24'h000000, st_q.rdata};
    assign md                = st_q.timer01_mode_register;
    assign t2ctl             = st_q.third_timer_control;

    // t2_external_flag counts as a count bit in up/down mode, so it is kept off the request
    assign flags_o.timer0_overflow_flag = st_q.ovf_flag[0];
    assign flags_o.timer1_overflow_flag = st_q.ovf_flag[1];
    assign flags_o.t2_irq_req = t2ctl[`TTC_T2C_TF] | (t2ctl[`TTC_T2C_EXF] & ~t2_updown);

    // next-state logic for the whole unit
    always_comb begin
        st_d      = st_q;
        pin_lvl   = st_q.sync2;
        pin_fall  = st_q.prev & ~st_q.sync2;
        mcyc      = (st_q.prescale == PRE_LAST);
        set_f     = '0;
        lo_tick   = '0;
        mf        = TTC_M13;
        c13       = '0;
        c16       = '0;
        rd8       = '0;
        t2_set_tf = 1'b0;
        t2_set_ex = 1'b0;
        t2_tog_ex = 1'b0;
        // two stages per pin; only stage two and its delayed copy are read
        st_d.sync1    = pins_i;
        st_d.sync2    = st_q.sync1;
        st_d.prev     = st_q.sync2;
        st_d.prescale = mcyc ? '0 : st_q.prescale + 1'b1;
        split0 = (ttc_tmode_e'(md[`TTC_MODE_M +: 2]) == TTC_MSPLIT);

        // timers 0 and 1 share one body; the mode field picks the width
        for (int i = 0; i < 2; i++) begin
            mf = ttc_tmode_e'(md[i*`TTC_MODE_STRIDE + `TTC_MODE_M +: 2]);
            lo_tick[i] = (md[i*`TTC_MODE_STRIDE + `TTC_MODE_CT] ? pin_fall[`TTC_PIN_T0CNT + i] : mcyc)
                       & (st_q.run[i] | (i == 1 && split0))
                       & (~md[i*`TTC_MODE_STRIDE + `TTC_MODE_Q] | pin_lvl[`TTC_PIN_IRQA + i]);
            if (i == 1 && mf == TTC_MSPLIT) begin
                lo_tick[i] = 1'b0;
            end
            // count continues from the held value, run never clears it
            if (lo_tick[i]) begin
                case (mf)
                    TTC_M13: begin
                        // upper low-byte bits are left alone in this mode
                        c13 = {st_q.high_byte[i], st_q.low_byte[i][`TTC_LOW_W-1:0]} + 13'h0001;
                        st_d.high_byte[i] = c13[12:`TTC_LOW_W];
                        st_d.low_byte[i][`TTC_LOW_W-1:0] = c13[`TTC_LOW_W-1:0];
                        set_f[i] = (c13 == '0);
                    end
                    TTC_M16: begin
                        c16 = {st_q.high_byte[i], st_q.low_byte[i]} + 16'h0001;
                        {st_d.high_byte[i], st_d.low_byte[i]} = c16;
                        set_f[i] = (c16 == '0);
                    end
                    TTC_M8RL: begin
                        if (st_q.low_byte[i] == `TTC_ONES8) begin
                            st_d.low_byte[i] = st_q.high_byte[i];
                            set_f[i] = 1'b1;
                        end else begin
                            st_d.low_byte[i] = st_q.low_byte[i] + 8'h01;
                        end
                    end
                    default: begin
                        // only timer 0 gets here: its low byte alone
                        st_d.low_byte[i] = st_q.low_byte[i] + 8'h01;
                        set_f[i] = (st_q.low_byte[i] == `TTC_ONES8);
                    end
                endcase
            end
        end

        // split mode: timer 0 high byte borrows timer 1 run and flag
        if (split0) begin
            set_f[1] = 1'b0;
            if (st_q.run[1] && mcyc) begin
                st_d.high_byte[0] = st_q.high_byte[0] + 8'h01;
                set_f[1] = (st_q.high_byte[0] == `TTC_ONES8);
            end
        end

        // timer 2 mode decode
        t2c       = {st_q.t2_count_high, st_q.t2_count_low};
        t2r       = {st_q.t2_reload_high, st_q.t2_reload_low};
        t2n       = t2c;
        t2_baud   = t2ctl[`TTC_T2C_RXB] | t2ctl[`TTC_T2C_TXB];
        t2_cap    = t2ctl[`TTC_T2C_CAP] & ~t2_baud;
        t2_updown = ~t2_baud & ~t2_cap & st_q.third_timer_mode[`TTC_T2M_DOWN_COUNT_ENABLE];
        t2_tick   = t2ctl[`TTC_T2C_RUN]
                  & (t2ctl[`TTC_T2C_CT] ? pin_fall[`TTC_PIN_T2CNT] : mcyc);

        if (t2_updown) begin
            // the external enable bit has no say in this mode
            if (t2_tick) begin
                if (pin_lvl[`TTC_PIN_T2_CAPTURE_DIRECTION_PIN]) begin
                    if (t2c == `TTC_ONES16) begin
                        t2n       = t2r;
                        t2_set_tf = 1'b1;
                        t2_tog_ex = 1'b1;
                    end else begin
                        t2n = t2c + 16'h0001;
                    end
                end else if (t2c == t2r) begin
                    t2n       = `TTC_ONES16;
                    t2_set_tf = 1'b1;
                    t2_tog_ex = 1'b1;
                end else begin
                    t2n = t2c - 16'h0001;
                end
            end
        end else begin
            if (t2_tick) begin
                if (t2c == `TTC_ONES16) begin
                    // capture mode wraps to zero, others reload
                    t2n       = t2_cap ? '0 : t2r;
                    t2_set_tf = ~t2_baud;
                end else begin
                    t2n = t2c + 16'h0001;
                end
            end
            if (t2ctl[`TTC_T2C_EXEN] && pin_fall[`TTC_PIN_T2_CAPTURE_DIRECTION_PIN]) begin
                t2_set_ex = 1'b1;
                if (t2_cap) begin
                    {st_d.t2_reload_high, st_d.t2_reload_low} = t2c;
                end else if (!t2_baud) begin
                    t2n = t2r;
                end
            end
        end
        {st_d.t2_count_high, st_d.t2_count_low} = t2n;

        // bus: one wait cycle, read data snapped in the first cycle
        st_d.ack = req & ~st_q.ack;
        wr_act   = avs_req_i.write & st_q.ack & avs_req_i.byteenable[0];
        wd       = avs_req_i.writedata[7:0];
        addr     = {avs_req_i.address[`TTC_ADDR_W-1:2], 2'b00};
        if (addr == `TTC_OFF_MODE01) begin
            rd8 = md;
        end else if (addr == `TTC_OFF_CTL01) begin
            rd8[`TTC_CTL_TF1] = st_q.ovf_flag[1];
            rd8[`TTC_CTL_TR1] = st_q.run[1];
            rd8[`TTC_CTL_TF0] = st_q.ovf_flag[0];
            rd8[`TTC_CTL_TR0] = st_q.run[0];
        end else if (addr == `TTC_OFF_T0L) begin
            rd8 = st_q.low_byte[0];
        end else if (addr == `TTC_OFF_T0H) begin
            rd8 = st_q.high_byte[0];
        end else if (addr == `TTC_OFF_T1L) begin
            rd8 = st_q.low_byte[1];
        end else if (addr == `TTC_OFF_T1H) begin
            rd8 = st_q.high_byte[1];
        end else if (addr == `TTC_OFF_T2CTL) begin
            rd8 = t2ctl;
        end else if (addr == `TTC_OFF_THIRD_TIMER_MODE) begin
            rd8[1:0] = st_q.third_timer_mode;
        end else if (addr == `TTC_OFF_T2CL) begin
            rd8 = st_q.t2_count_low;
        end else if (addr == `TTC_OFF_T2CH) begin
            rd8 = st_q.t2_count_high;
        end else if (addr == `TTC_OFF_T2RL) begin
            rd8 = st_q.t2_reload_low;
        end else if (addr == `TTC_OFF_T2RH) begin
            rd8 = st_q.t2_reload_high;
        end
        if (req && !st_q.ack) begin
            st_d.rdata = rd8;
        end

        // a software write wins over counting on the data registers
        if (wr_act) begin
            if (addr == `TTC_OFF_MODE01) begin
                st_d.timer01_mode_register = wd;
            end else if (addr == `TTC_OFF_CTL01) begin
                st_d.run      = {wd[`TTC_CTL_TR1], wd[`TTC_CTL_TR0]};
                st_d.ovf_flag = {wd[`TTC_CTL_TF1], wd[`TTC_CTL_TF0]};
            end else if (addr == `TTC_OFF_T0L) begin
                st_d.low_byte[0] = wd;
            end else if (addr == `TTC_OFF_T0H) begin
                st_d.high_byte[0] = wd;
            end else if (addr == `TTC_OFF_T1L) begin
                st_d.low_byte[1] = wd;
            end else if (addr == `TTC_OFF_T1H) begin
                st_d.high_byte[1] = wd;
            end else if (addr == `TTC_OFF_T2CTL) begin
                st_d.third_timer_control = wd;
            end else if (addr == `TTC_OFF_THIRD_TIMER_MODE) begin
                st_d.third_timer_mode = wd[1:0];
            end else if (addr == `TTC_OFF_T2CL) begin
                st_d.t2_count_low = wd;
            end else if (addr == `TTC_OFF_T2CH) begin
                st_d.t2_count_high = wd;
            end else if (addr == `TTC_OFF_T2RL) begin
                st_d.t2_reload_low = wd;
            end else if (addr == `TTC_OFF_T2RH) begin
                st_d.t2_reload_high = wd;
            end
        end

        // flag sets and toggles land on top of any write, so none is lost
        st_d.ovf_flag = st_d.ovf_flag | set_f;
        st_d.third_timer_control[`TTC_T2C_TF] = st_d.third_timer_control[`TTC_T2C_TF] | t2_set_tf;
        st_d.third_timer_control[`TTC_T2C_EXF] =
            (st_d.third_timer_control[`TTC_T2C_EXF] ^ t2_tog_ex) | t2_set_ex;
    end

    // single state register; ce low freezes everything
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_q <= `TTC_STATE_RST;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    bus_one_wait_a: assert property (ce_i && req && avs_waitrequest_o && !st_q.ack |=> ce_i |-> !avs_waitrequest_o)
        else $error("bus answer not one cycle after request");
    tf0_set_a: assert property (ce_i && set_f[0] |=> st_q.ovf_flag[0])
        else $error("timer 0 overflow did not set its flag");
    mode0_wrap_a: assert property (ce_i && !wr_act && lo_tick[0] && md[`TTC_MODE_M +: 2] == TTC_M13
        && st_q.high_byte[0] == `TTC_ONES8 && &st_q.low_byte[0][`TTC_LOW_W-1:0]
        |=> st_q.high_byte[0] == '0 && st_q.low_byte[0][`TTC_LOW_W-1:0] == '0 && st_q.ovf_flag[0])
        else $error("13-bit wrap wrong");
    mode2_reload_a: assert property (ce_i && !wr_act && lo_tick[0] && md[`TTC_MODE_M +: 2] == TTC_M8RL
        && st_q.low_byte[0] == `TTC_ONES8
        |=> st_q.low_byte[0] == $past(st_q.high_byte[0]) && $stable(st_q.high_byte[0]))
        else $error("8-bit reload wrong");
    t1_hold_a: assert property (ce_i && !wr_act && md[`TTC_MODE_STRIDE + `TTC_MODE_M +: 2] == TTC_MSPLIT
        |=> $stable(st_q.low_byte[1]) && $stable(st_q.high_byte[1]))
        else $error("timer 1 counted in mode 3");
    qualify_stop_a: assert property (ce_i && !wr_act && md[`TTC_MODE_Q] && !pin_lvl[`TTC_PIN_IRQA]
        && !split0 |=> $stable(st_q.low_byte[0]) && $stable(st_q.high_byte[0]))
        else $error("timer 0 counted while qualified off");
    split_hi_a: assert property (ce_i && !wr_act && split0 && st_q.run[1] && mcyc
        && st_q.high_byte[0] == `TTC_ONES8 |=> st_q.high_byte[0] == '0 && st_q.ovf_flag[1])
        else $error("split high byte wrap wrong");
    t2_stop_a: assert property (ce_i && !wr_act && !t2ctl[`TTC_T2C_RUN] && !t2_set_ex
        |=> $stable(st_q.t2_count_low) && $stable(st_q.t2_count_high))
        else $error("timer 2 counted while stopped");
    capture_copy_a: assert property (ce_i && !wr_act && t2_cap && t2ctl[`TTC_T2C_EXEN]
        && pin_fall[`TTC_PIN_T2_CAPTURE_DIRECTION_PIN] |=> {st_q.t2_reload_high, st_q.t2_reload_low} == $past(t2c)
        && st_q.third_timer_control[`TTC_T2C_EXF])
        else $error("capture did not copy count");
    down_wrap_a: assert property (ce_i && !wr_act && t2_updown && t2_tick && !pin_lvl[`TTC_PIN_T2_CAPTURE_DIRECTION_PIN]
        && t2c == t2r |=> t2c == `TTC_ONES16 && st_q.third_timer_control[`TTC_T2C_TF]
        && st_q.third_timer_control[`TTC_T2C_EXF] != $past(t2ctl[`TTC_T2C_EXF]))
        else $error("down-count underflow wrong");
    updown_req_a: assert property (t2_updown |-> flags_o.t2_irq_req == t2ctl[`TTC_T2C_TF])
        else $error("external flag raised a request in up/down mode");
    down_count_enable_reset_a: assert property ($past(sys_rst_i) |-> !st_q.third_timer_mode[`TTC_T2M_DOWN_COUNT_ENABLE])
        else $error("down-count enable not cleared by reset");

    capture_seen_c: cover property (ce_i && t2_cap && t2_set_ex);
    down_wrap_c: cover property (ce_i && t2_updown && t2_tog_ex && !pin_lvl[`TTC_PIN_T2_CAPTURE_DIRECTION_PIN]);
    reload8_c: cover property (ce_i && lo_tick[0] && md[`TTC_MODE_M +: 2] == TTC_M8RL && set_f[0]);
    split_hi_c: cover property (ce_i && split0 && set_f[1]);
endmodule : ttc_top

// >>> testbench/ttc_pin_model.sv
`timescale 1ns/10ps
// far-side pins: count, gate and capture lines, idle high like pulled-up inputs
module ttc_pin_model (
    input  wire logic          clk_sys_i,
    output ttc_pkg::ttc_pins_s pins_o
);
    import ttc_pkg::*;
    logic [5:0] lvl_q = 6'h3f;
    assign pins_o = lvl_q;
    // one falling edge; each level kept 4 cycles so the two-flop sync never misses it
    task pulse(input int idx);
        lvl_q[idx] <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        lvl_q[idx] <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask : pulse
    // static level for gate or count direction
    task hold(input int idx, input logic v);
        lvl_q[idx] <= v;
        repeat (4) @(posedge clk_sys_i);
    endtask : hold
endmodule : ttc_pin_model

// >>> testbench/test_three_timer_counter_unit.sv
`timescale 1ns/10ps
module test_three_timer_counter_unit;
    import ttc_pkg::*;
    typedef struct {
        logic [5:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } ttc_row_s;
    logic         clk_sys_i;
    logic         sys_rst_i;
    ttc_avs_req_s req;
    logic [31:0]  rdata;
    logic         wait_rq;
    logic         ce;
    logic [3:0]   be;
    ttc_pins_s    pins;
    ttc_flags_s   flags;
    logic [7:0]   q;
    int           err_count;
    int           checks;
    ttc_row_s     rows [8];

    // short machine cycle keeps the run brief
    ttc_top #(.MCYC_DIV(2)) uut (
        .clk_sys_i        (clk_sys_i),
        .sys_rst_i        (sys_rst_i),
        .ce_i             (ce),
        .avs_req_i        (req),
        .avs_readdata_o   (rdata),
        .avs_waitrequest_o(wait_rq),
        .pins_i           (pins),
        .flags_o          (flags)
    );
    ttc_pin_model pm (
        .clk_sys_i(clk_sys_i),
        .pins_o   (pins)
    );

    task tally_and_finish;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request stands until waitrequest is sampled low at a rising edge; data taken at that edge
    task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{read: !w, write: w, address: a, byteenable: be, writedata: {4{d}}};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wait_rq !== 1'b0 && n < 40);
        if (wait_rq !== 1'b0) begin
            err_count++;
            $display("Error %0t bus timeout", $time);
            tally_and_finish();
        end else begin
            q = rdata[7:0];
            req <= '0;
            // one idle edge so the next request never reassigns req in this step
            @(posedge clk_sys_i);
        end
    endtask : bus

    task wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd

    // free-running 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        ce = 1'b1;
        be = 4'h1;
        err_count = 0;
        checks = 0;
        rows = '{'{6'h00, 8'h66, 8'h66}, '{6'h04, 8'h0f, 8'h00}, '{6'h08, 8'h3c, 8'h3c},
                 '{6'h14, 8'hc3, 8'hc3}, '{6'h1c, 8'hff, 8'h03}, '{6'h2c, 8'h5a, 8'h5a},
                 '{6'h30, 8'h55, 8'h00}, '{6'h18, 8'h20, 8'h20}};
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(6'h1c, 8'h00);
        // register rows, all timers stopped
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // 13-bit count starts from preset value and rolls over
        wr(6'h00, 8'h04);
        wr(6'h08, 8'h1e);
        wr(6'h0c, 8'hff);
        wr(6'h04, 8'h10);
        pm.pulse(0);
        rd(6'h08, 8'h1f);
        pm.pulse(0);
        rd(6'h08, 8'h00);
        rd(6'h0c, 8'h00);
        rd(6'h04, 8'h30);
        chk({7'h0, flags.timer0_overflow_flag}, 8'h01);
        // 16-bit count gated by the irq pin through the qualify bit
        wr(6'h04, 8'h10);
        wr(6'h00, 8'h0d);
        wr(6'h08, 8'hff);
        wr(6'h0c, 8'h00);
        pm.hold(3, 1'b0);
        pm.pulse(0);
        rd(6'h08, 8'hff);
        pm.hold(3, 1'b1);
        pm.pulse(0);
        rd(6'h08, 8'h00);
        rd(6'h0c, 8'h01);
        // timer 1 8-bit reload, then mode 3 freezes it
        wr(6'h00, 8'h6d);
        wr(6'h14, 8'h80);
        wr(6'h10, 8'hff);
        wr(6'h04, 8'h50);
        pm.pulse(1);
        rd(6'h10, 8'h80);
        rd(6'h14, 8'h80);
        rd(6'h04, 8'hd0);
        wr(6'h00, 8'h7d);
        pm.pulse(1);
        rd(6'h10, 8'h80);
        // timer 0 split: high byte wraps on timer 1 run and flag, timer 1 counts on
        wr(6'h04, 8'h00);
        wr(6'h00, 8'h43);
        wr(6'h0c, 8'hff);
        wr(6'h04, 8'h40);
        pm.pulse(1);
        rd(6'h10, 8'h81);
        rd(6'h04, 8'hc0);
        // enable low freezes the pin sync, so this fall is never seen
        ce <= 1'b0;
        pm.pulse(1);
        ce <= 1'b1;
        rd(6'h10, 8'h81);
        // write without its byte lane stores nothing
        be = 4'he;
        wr(6'h14, 8'h00);
        be = 4'h1;
        rd(6'h14, 8'h80);
        // timer 2 capture on a capture-pin fall, then keeps counting
        wr(6'h1c, 8'h00);
        wr(6'h20, 8'h34);
        wr(6'h24, 8'h12);
        wr(6'h18, 8'h0f);
        pm.pulse(5);
        rd(6'h28, 8'h34);
        rd(6'h2c, 8'h12);
        rd(6'h18, 8'h4f);
        chk({7'h0, flags.t2_irq_req}, 8'h01);
        pm.pulse(2);
        rd(6'h20, 8'h35);
        // down count to the reload value, then up through ffff
        wr(6'h18, 8'h00);
        wr(6'h1c, 8'h01);
        pm.hold(5, 1'b0);
        wr(6'h28, 8'h10);
        wr(6'h2c, 8'h00);
        wr(6'h20, 8'h11);
        wr(6'h24, 8'h00);
        wr(6'h18, 8'h06);
        pm.pulse(2);
        rd(6'h20, 8'h10);
        pm.pulse(2);
        rd(6'h20, 8'hff);
        rd(6'h24, 8'hff);
        rd(6'h18, 8'hc6);
        wr(6'h18, 8'h46);
        chk({7'h0, flags.t2_irq_req}, 8'h00);
        pm.hold(5, 1'b1);
        pm.pulse(2);
        rd(6'h20, 8'h10);
        rd(6'h18, 8'h86);
        // up-only reload forced by a capture-pin fall
        wr(6'h1c, 8'h00);
        wr(6'h18, 8'h0e);
        wr(6'h20, 8'h77);
        pm.pulse(5);
        rd(6'h20, 8'h10);
        rd(6'h18, 8'h4e);
        chk({7'h0, flags.t2_irq_req}, 8'h01);
        // up-only overflow reloads from the reload pair
        wr(6'h18, 8'h06);
        wr(6'h20, 8'hff);
        wr(6'h24, 8'hff);
        pm.pulse(2);
        rd(6'h20, 8'h10);
        rd(6'h18, 8'h86);
        // capture-mode overflow wraps to zero with no reload
        wr(6'h18, 8'h07);
        wr(6'h20, 8'hff);
        wr(6'h24, 8'hff);
        pm.pulse(2);
        rd(6'h24, 8'h00);
        rd(6'h18, 8'h87);
        // a run-bit clear stops timer 2 in up-only reload mode
        wr(6'h18, 8'h0a);
        pm.pulse(2);
        rd(6'h20, 8'h00);
        wr(6'h1c, 8'h01);
        // second reset mid-run clears everything again
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(6'h04, 8'h00);
        rd(6'h1c, 8'h00);
        tally_and_finish();
    end
endmodule : test_three_timer_counter_unit
